// ---- hw/smc_pkg.sv ----
// types shared by the standby controller modules
package smc_pkg;

    typedef enum logic [2:0] {
        st_rst_settle,
        st_run,
        st_light,
        st_deep,
        st_settle,
        st_wait
    } smc_state_t;

    typedef struct packed {
        logic timer;
        logic watchdog;
        logic watch;
        logic display;
        logic display_hold;
        logic serial;
    } smc_periph_t;

endpackage : smc_pkg

// ---- hw/smc_regs.svh ----
// register offsets, reset values, field positions and timing counts for the standby controller
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// settle select register
`define SMC_SETTLE_SEL_ADDR   16'hFFFA
`define SMC_SETTLE_SEL_RESET  3'h4
`define SMC_SETTLE_SEL_MSB    2
`define SMC_SETTLE_SEL_LSB    0

// legal settle select codes
`define SMC_CODE_2P12         3'h0
`define SMC_CODE_2P15         3'h2
`define SMC_CODE_2P17         3'h4

////////////////////////////////////////////////////////////////////////////////
// settle waits in main oscillator periods
`define SMC_SETTLE_2P12_FX    18'h01000
`define SMC_SETTLE_2P15_FX    18'h08000
`define SMC_SETTLE_2P17_FX    18'h20000

// wake waits in cpu clocks, least figures
`define SMC_WAKE_VEC_CLK      4'h9
`define SMC_WAKE_NEXT_CLK     4'h1

// maskable sources: two mask registers, eight plus four flags
`define SMC_NUM_INT           12

`endif

// ---- hw/smc_settle_cnt.sv ----
// oscillation settle counter, counts oscillator periods up to a target
module smc_settle_cnt
    import smc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // control
    input  wire logic        clear,
    input  wire logic        tick,
    input  wire logic [17:0] target,
    // status
    output logic             done
);

    logic [17:0] count;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 18'h00000;
        end else if (clear) begin
            count <= 18'h00000;
        end else if (tick && (count != target)) begin
            count <= count + 18'h00001; // R22
        end
    end

    assign done = !clear && (count == target); // R22

    ////////////////////////////////////////////////////////////////////////////
    settle_tick_only_a : assert property ( // R6
        @(posedge ref_clk) disable iff (!rst_b)
        (!clear && !tick) |=> (count == $past(count)) || $past(clear))
        else $error("settle count moved without an oscillator tick");

    settle_done_exact_a : assert property ( // R22
        @(posedge ref_clk) disable iff (!rst_b)
        done |-> (count == target) && (count != 18'h00000 || target == 18'h00000))
        else $error("settle done before target count");

endmodule : smc_settle_cnt

// ---- hw/smc_standby.sv ----
// standby controller: light sleep, deep sleep, settle wait and wake sequencing
//
// Notes on behaviour
// R1 - light sleep gates the cpu clock; main oscillator keeps running.
// R2 - deep sleep stops the main oscillator and halts the whole system.
// R3 - both sleeps keep registers, memory, port latches and buffers unchanged.
// R4 - reset loads settle select 04H, yet the post-reset settle is 2^15.
// R5 - settle codes 000/010/100 give 2^12/2^15/2^17; upper five bits read zero.
// R6 - settle wait counts only from oscillation start, not before.
// R7 - light sleep: timers run unless main clock stopped; watchdog, display stop. Here the watchdog stops only while sub_clk_sel is set.
// R8 - deep sleep stops cpu, timers, watchdog, display; watch timer needs subclock.
// R9 - while asleep, serial runs only on its external clock.
// R10 - unmasked request ends light sleep; vector if enabled, else next instruction.
// R11 - light wake waits 9-10 clocks before vectoring, 1-2 before resuming.
// R12 - non-maskable request ends light sleep always and always vectors.
// R13 - reset during light sleep branches to reset vector as usual.
// R14 - deep sleep pulls oscillator output pins up to supply.
// R15 - deep sleep with unmasked request pending drops to light sleep and settles.
// R16 - only unmasked maskable requests or reset release deep sleep.
// R17 - interrupt release of deep sleep vectors after settle if enabled.
// R18 - reset release of deep sleep starts reset processing after settle.
// R19 - software halts all peripherals before entering deep sleep.
// R20 - global enable one permits acknowledgement, zero blocks it.
// R21 - request counts unmasked when request flag is 1 and mask is 0.
// R22 - settle counter counts oscillator periods to the selected power of two.
`include "smc_regs.svh"
module smc_standby
    import smc_pkg::*;
#(
    parameter logic [17:0] SETTLE_2P12 = `SMC_SETTLE_2P12_FX,
    parameter logic [17:0] SETTLE_2P15 = `SMC_SETTLE_2P15_FX,
    parameter logic [17:0] SETTLE_2P17 = `SMC_SETTLE_2P17_FX
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    // cpu instruction strobes
    input  wire logic                     halt_exec,
    input  wire logic                     stop_exec,
    // special function register access
    input  wire logic [15:0]              sfr_addr,
    input  wire logic                     sfr_wr,
    input  wire logic                     sfr_rd,
    input  wire logic [7:0]               sfr_wdata,
    output logic      [7:0]               sfr_rdata,
    // interrupt state
    input  wire logic [`SMC_NUM_INT-1:0]  int_request_flag,
    input  wire logic [`SMC_NUM_INT-1:0]  int_mask_flag,
    input  wire logic                     global_int_enable,
    input  wire logic                     nmi_req,
    // main oscillator
    input  wire logic                     osc_tick,
    input  wire logic                     osc_running,
    output logic                          osc_enable,
    output logic                          main_osc_out_pin_o,
    output logic                          main_osc_out_pin_oe,
    output logic                          alt_osc_out_pin_o,
    output logic                          alt_osc_out_pin_oe,
    // clock selections
    input  wire logic                     sub_clk_sel,
    input  wire logic                     main_clk_stopped,
    input  wire logic                     serial_ext_clk,
    // cpu control
    output logic                          cpu_clk_en,
    output logic                          cpu_reset_hold,
    output logic                          state_hold,
    output logic                          wake_vector,
    output logic                          wake_resume,
    // peripheral run enables
    output smc_periph_t                   periph
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    smc_state_t  state;
    smc_state_t  next_state;
    logic [2:0]  settle_sel;
    logic [17:0] settle_target;
    logic        settle_done;
    logic        settle_clear;
    logic        wake_pend;
    logic        vec_pend;
    logic        next_vec_pend;
    logic [3:0]  wait_cnt;
    logic [3:0]  next_wait_cnt;
    logic        sel_hit;
    smc_periph_t next_periph;

    ////////////////////////////////////////////////////////////////////////////
    // wake qualification
    assign wake_pend = |(int_request_flag & ~int_mask_flag); // R21
    assign sel_hit   = (sfr_addr == `SMC_SETTLE_SEL_ADDR);

    ////////////////////////////////////////////////////////////////////////////
    // settle select register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_sel <= `SMC_SETTLE_SEL_RESET; // R4
        end else if (sfr_wr && sel_hit) begin
            // prohibited codes are dropped and the old choice stays
            if (sfr_wdata[`SMC_SETTLE_SEL_MSB:`SMC_SETTLE_SEL_LSB] == `SMC_CODE_2P12 ||
                sfr_wdata[`SMC_SETTLE_SEL_MSB:`SMC_SETTLE_SEL_LSB] == `SMC_CODE_2P15 ||
                sfr_wdata[`SMC_SETTLE_SEL_MSB:`SMC_SETTLE_SEL_LSB] == `SMC_CODE_2P17) begin
                settle_sel <= sfr_wdata[`SMC_SETTLE_SEL_MSB:`SMC_SETTLE_SEL_LSB]; // R5
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd && sel_hit) begin
            sfr_rdata <= {5'h00, settle_sel}; // R5
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settle target and counter
    always_comb begin
        if (state == st_rst_settle) begin
            settle_target = SETTLE_2P15; // R4
        end else if (settle_sel == `SMC_CODE_2P12) begin
            settle_target = SETTLE_2P12; // R5
        end else if (settle_sel == `SMC_CODE_2P15) begin
            settle_target = SETTLE_2P15; // R5
        end else begin
            settle_target = SETTLE_2P17; // R5
        end
    end

    assign settle_clear = (state != st_rst_settle) && (state != st_settle);

    smc_settle_cnt u_settle (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clear   (settle_clear),
        .tick    (osc_tick && osc_running), // R6
        .target  (settle_target),
        .done    (settle_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencing
    always_comb begin
        next_state    = state;
        next_vec_pend = vec_pend;
        next_wait_cnt = wait_cnt;
        case (state)
            st_rst_settle: begin
                // reset processing waits for the settle time
                if (settle_done) begin
                    next_state = st_run; // R18 R13
                end
            end
            st_run: begin
                if (stop_exec && wake_pend) begin
                    next_state = st_settle; // R15
                end else if (stop_exec) begin
                    next_state = st_deep; // R2
                end else if (halt_exec) begin
                    next_state = st_light; // R1
                end
            end
            st_light: begin
                if (nmi_req) begin
                    next_state    = st_wait; // R12
                    next_vec_pend = 1'b1; // R12
                    next_wait_cnt = `SMC_WAKE_VEC_CLK; // R11
                end else if (wake_pend) begin
                    next_state    = st_wait; // R10
                    next_vec_pend = global_int_enable; // R10 R20
                    next_wait_cnt = global_int_enable ? `SMC_WAKE_VEC_CLK
                                                      : `SMC_WAKE_NEXT_CLK; // R11
                end
            end
            st_deep: begin
                // masked requests and the non-maskable line leave it asleep
                if (wake_pend) begin
                    next_state = st_settle; // R16
                end
            end
            st_settle: begin
                if (settle_done) begin
                    next_state    = st_wait; // R17
                    next_vec_pend = global_int_enable; // R17 R20
                    next_wait_cnt = `SMC_WAKE_NEXT_CLK;
                end
            end
            st_wait: begin
                if (wait_cnt == 4'h1) begin
                    next_state = st_run;
                end else begin
                    next_wait_cnt = wait_cnt - 4'h1;
                end
            end
            default: begin
                next_state = st_run;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= st_rst_settle;
            vec_pend <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            state    <= next_state;
            vec_pend <= next_vec_pend;
            wait_cnt <= next_wait_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cpu control outputs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_clk_en     <= 1'b0;
            cpu_reset_hold <= 1'b1;
            state_hold     <= 1'b1;
        end else begin
            cpu_clk_en     <= (next_state == st_run); // R1 R2
            cpu_reset_hold <= (next_state == st_rst_settle); // R18
            state_hold     <= (next_state != st_run); // R3
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_vector <= 1'b0;
            wake_resume <= 1'b0;
        end else begin
            wake_vector <= (state == st_wait) && (wait_cnt == 4'h1) && vec_pend; // R10 R17
            wake_resume <= (state == st_wait) && (wait_cnt == 4'h1) && !vec_pend; // R10 R17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator control
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_enable          <= 1'b1;
            main_osc_out_pin_oe <= 1'b0;
            alt_osc_out_pin_oe  <= 1'b0;
        end else begin
            osc_enable          <= (next_state != st_deep); // R2
            main_osc_out_pin_oe <= (next_state == st_deep); // R14
            alt_osc_out_pin_oe  <= (next_state == st_deep); // R14
        end
    end

    // pull-up level only, the enable decides when it is seen
    assign main_osc_out_pin_o = 1'b1;
    assign alt_osc_out_pin_o  = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // peripheral run enables
    always_comb begin
        next_periph = '0;
        case (next_state)
            st_run: begin
                next_periph.timer    = 1'b1;
                next_periph.watchdog = 1'b1;
                next_periph.watch    = 1'b1;
                next_periph.display  = 1'b1;
                next_periph.serial   = 1'b1;
            end
            st_light: begin
                next_periph.timer        = !main_clk_stopped; // R7
                next_periph.watchdog     = !sub_clk_sel; // R7
                next_periph.watch        = 1'b1;
                next_periph.display_hold = 1'b1; // R7
                next_periph.serial       = serial_ext_clk; // R9
            end
            default: begin
                // deep sleep, settle waits and wake wait: system halted
                next_periph.watch        = sub_clk_sel; // R8
                next_periph.display_hold = 1'b1; // R8
                next_periph.serial       = serial_ext_clk; // R9
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph <= '0;
        end else begin
            periph <= next_periph;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    light_cpu_gate_a : assert property ( // R1
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_light) |-> !cpu_clk_en && osc_enable && state_hold)
        else $error("light sleep must gate cpu and keep oscillator");

    deep_osc_stop_a : assert property ( // R2
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_deep) |-> !osc_enable && !cpu_clk_en)
        else $error("deep sleep must stop the oscillator");

    deep_pullup_a : assert property ( // R14
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_deep) |-> main_osc_out_pin_oe && alt_osc_out_pin_oe)
        else $error("oscillator pins not pulled up in deep sleep");

    settle_read_a : assert property ( // R5
        @(posedge ref_clk) disable iff (!rst_b)
        (sfr_rd && sel_hit) |=> (sfr_rdata[7:3] == 5'h00) && (sfr_rdata[2:0] == $past(settle_sel)))
        else $error("settle select read back wrong");

    reset_settle_a : assert property ( // R4
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_rst_settle) |-> (settle_target == SETTLE_2P15) && cpu_reset_hold)
        else $error("reset settle must use the 2^15 wait");

    deep_masked_a : assert property ( // R16
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_deep && !wake_pend) |=> (state == st_deep))
        else $error("deep sleep left without unmasked request");

    stop_pending_a : assert property ( // R15
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_run && stop_exec && wake_pend) |=> (state == st_settle) && osc_enable)
        else $error("stop with pending request must settle");

    nmi_vector_a : assert property ( // R12
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_light && nmi_req) |-> ##10 (wake_vector && !wake_resume))
        else $error("nmi wake must vector after the wait");

    light_resume_a : assert property ( // R11
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_light && !nmi_req && wake_pend && !global_int_enable)
            |-> ##2 (wake_resume && cpu_clk_en))
        else $error("resume wake took the wrong time");

    settle_release_a : assert property ( // R17
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_settle && settle_done && global_int_enable) |-> ##2 wake_vector)
        else $error("deep wake did not vector after settle");

    deep_periph_a : assert property ( // R8
        @(posedge ref_clk) disable iff (!rst_b)
        (state == st_deep) |-> !periph.timer && !periph.watchdog && !periph.display && periph.display_hold)
        else $error("peripherals running in deep sleep");

    sleep_serial_a : assert property ( // R9
        @(posedge ref_clk) disable iff (!rst_b)
        (state != st_run && state != st_rst_settle && !$past(serial_ext_clk)) |-> !periph.serial)
        else $error("serial running asleep without external clock");

endmodule : smc_standby

// ---- sim/smc_osc_model.sv ----
// main oscillator model on the far side: start-up delay, then one tick per two clocks
module smc_osc_model #(
    parameter int START_DLY = 5
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // oscillator control and status
    input  wire logic osc_enable,
    output logic      osc_tick,
    output logic      osc_running
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] start_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // start-up delay before oscillation; stops at once when disabled
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            start_cnt   <= 8'h00;
            osc_running <= 1'b0;
        end else if (!osc_enable) begin
            start_cnt   <= 8'h00;
            osc_running <= 1'b0;
        end else if (start_cnt < 8'(START_DLY)) begin
            start_cnt   <= start_cnt + 8'h01;
        end else begin
            osc_running <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= osc_running & osc_enable & ~osc_tick;
        end
    end
endmodule : smc_osc_model

// ---- sim/smc_standby_bench.sv ----
// self-checking bench for the standby controller
`include "smc_regs.svh"
module smc_standby_bench
    import smc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int S12 = 4;
    localparam int S15 = 8;
    localparam int S17 = 16;

    logic ref_clk = 1'b0, rst_b = 1'b0, halt_exec = 1'b0, stop_exec = 1'b0;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, global_int_enable = 1'b0, nmi_req = 1'b0;
    logic [15:0] sfr_addr = 16'h0000;
    logic [7:0]  sfr_wdata = 8'h00, sfr_rdata, rd_val;
    logic [`SMC_NUM_INT-1:0] int_request_flag = '0, int_mask_flag = '1;
    logic sub_clk_sel = 1'b1, main_clk_stopped = 1'b0, serial_ext_clk = 1'b1;
    logic osc_tick, osc_running, osc_enable, cpu_clk_en, cpu_reset_hold, state_hold;
    logic main_osc_out_pin_oe, alt_osc_out_pin_oe, wake_vector, wake_resume, vec;
    logic main_osc_out_pin_o, alt_osc_out_pin_o;
    smc_periph_t periph;
    int miscompares = 0, samples_checked = 0, n;

    typedef struct {logic [15:0] addr; logic [7:0] wdata; logic [7:0] exp;} smc_row_t;
    smc_row_t rows[7] = '{'{16'hFFFA, 8'h00, 8'h00}, '{16'hFFFA, 8'h02, 8'h02}, '{16'hFFFA, 8'h04, 8'h04},
                          '{16'hFFFA, 8'hFF, 8'h04}, '{16'hFFFA, 8'h0A, 8'h02}, '{16'hFFFA, 8'h03, 8'h02},
                          '{16'hFFFB, 8'h00, 8'h00}};

    always #4 ref_clk = ~ref_clk;

    smc_standby #(.SETTLE_2P12(18'(S12)), .SETTLE_2P15(18'(S15)), .SETTLE_2P17(18'(S17))) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .halt_exec(halt_exec), .stop_exec(stop_exec),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .int_request_flag(int_request_flag), .int_mask_flag(int_mask_flag),
        .global_int_enable(global_int_enable), .nmi_req(nmi_req), .osc_tick(osc_tick),
        .osc_running(osc_running), .osc_enable(osc_enable), .main_osc_out_pin_o(main_osc_out_pin_o),
        .main_osc_out_pin_oe(main_osc_out_pin_oe), .alt_osc_out_pin_o(alt_osc_out_pin_o),
        .alt_osc_out_pin_oe(alt_osc_out_pin_oe), .sub_clk_sel(sub_clk_sel),
        .main_clk_stopped(main_clk_stopped), .serial_ext_clk(serial_ext_clk), .cpu_clk_en(cpu_clk_en),
        .cpu_reset_hold(cpu_reset_hold), .state_hold(state_hold), .wake_vector(wake_vector),
        .wake_resume(wake_resume), .periph(periph));

    smc_osc_model osc (.ref_clk(ref_clk), .rst_b(rst_b), .osc_enable(osc_enable),
                       .osc_tick(osc_tick), .osc_running(osc_running));

    ////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic sfr_write(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask : sfr_write

    task automatic sfr_read(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : sfr_read

    // counts falling edges until the given signal is high
    task automatic wait_for(ref logic sig, output int cnt);
        cnt = 0;
        do begin
            @(negedge ref_clk);
            cnt++;
        end while (sig !== 1'b1 && cnt < 400);
    endtask : wait_for

    task automatic wait_wake(output int cnt);
        cnt = 0;
        do begin
            @(negedge ref_clk);
            cnt++;
        end while (!(wake_vector === 1'b1 || wake_resume === 1'b1) && cnt < 400);
        vec = wake_vector;
    endtask : wait_wake

    task automatic reset_settle();
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        check("reset_hold", cpu_reset_hold, 1'b1);
        sfr_read(16'hFFFA, rd_val);
        check("select_reset", rd_val, 8'h04);
        wait_for(osc_running, n);
        wait_for(cpu_clk_en, n);
        check("reset_settle", n inside {[2*S15:2*S15+6]}, 1'b1);
        check("reset_done", cpu_reset_hold, 1'b0);
    endtask : reset_settle

    task automatic light_wake(input logic ie, input logic nmi, input logic exp_vec);
        global_int_enable = ie;
        halt_exec = 1'b1;
        @(negedge ref_clk);
        halt_exec = 1'b0;
        int_request_flag = 12'h001;
        repeat (4) @(negedge ref_clk);
        check("light_cpu_clk", cpu_clk_en, 1'b0);
        check("light_osc", osc_enable, 1'b1);
        check("light_hold", state_hold, 1'b1);
        check("light_masked", wake_vector | wake_resume, 1'b0);
        check("light_periph", periph, {!main_clk_stopped, !sub_clk_sel, 1'b1, 1'b0, 1'b1, serial_ext_clk});
        if (nmi) nmi_req = 1'b1;
        else int_mask_flag = 12'hFFE;
        wait_wake(n);
        check("light_kind", vec, exp_vec);
        check("light_wait", exp_vec ? (n inside {[10:11]}) : (n inside {[2:3]}), 1'b1);
        check("light_clk_back", cpu_clk_en, 1'b1);
        nmi_req = 1'b0;
        int_request_flag = '0;
        int_mask_flag = '1;
        repeat (2) @(negedge ref_clk);
    endtask : light_wake

    task automatic deep_wake(input logic pend, input logic ie, input int exp_cnt);
        global_int_enable = ie;
        int_request_flag = 12'h800;
        if (pend) int_mask_flag = 12'h7FF;
        stop_exec = 1'b1;
        @(negedge ref_clk);
        stop_exec = 1'b0;
        @(negedge ref_clk);
        if (!pend) begin
            check("deep_osc", osc_enable, 1'b0);
            check("deep_pullup", {main_osc_out_pin_o, main_osc_out_pin_oe, alt_osc_out_pin_o, alt_osc_out_pin_oe},
                  4'hF);
            nmi_req = 1'b1;
            repeat (6) @(negedge ref_clk);
            check("deep_masked", osc_enable, 1'b0);
            check("deep_periph", periph, {1'b0, 1'b0, sub_clk_sel, 1'b0, 1'b1, serial_ext_clk});
            nmi_req = 1'b0;
            int_mask_flag = 12'h7FF;
            wait_for(osc_running, n);
        end else begin
            check("pend_osc", osc_enable, 1'b1);
        end
        wait_wake(n);
        check("deep_settle", n inside {[2*exp_cnt:2*exp_cnt+6]}, 1'b1);
        check("deep_kind", vec, ie);
        int_request_flag = '0;
        int_mask_flag = '1;
        repeat (2) @(negedge ref_clk);
    endtask : deep_wake

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        reset_settle();
        foreach (rows[i]) begin
            sfr_write(rows[i].addr, rows[i].wdata);
            sfr_read(rows[i].addr, rd_val);
            check("select_rw", rd_val, rows[i].exp);
        end
        light_wake(1'b1, 1'b0, 1'b1);
        light_wake(1'b0, 1'b0, 1'b0);
        // alternate clock choices while asleep
        sub_clk_sel = 1'b0;
        main_clk_stopped = 1'b1;
        serial_ext_clk = 1'b0;
        light_wake(1'b0, 1'b1, 1'b1);
        sub_clk_sel = 1'b1;
        main_clk_stopped = 1'b0;
        serial_ext_clk = 1'b1;
        sfr_write(16'hFFFA, 8'h00);
        deep_wake(1'b0, 1'b1, S12);
        sfr_write(16'hFFFA, 8'h04);
        sub_clk_sel = 1'b0;
        serial_ext_clk = 1'b0;
        deep_wake(1'b0, 1'b0, S17);
        sub_clk_sel = 1'b1;
        serial_ext_clk = 1'b1;
        sfr_write(16'hFFFA, 8'h02);
        deep_wake(1'b1, 1'b0, S15);
        halt_exec = 1'b1;
        @(negedge ref_clk);
        halt_exec = 1'b0;
        reset_settle();
        stop_exec = 1'b1;
        @(negedge ref_clk);
        stop_exec = 1'b0;
        @(negedge ref_clk);
        check("stop_before_reset", osc_enable, 1'b0);
        reset_settle();
        end_sim();
    end

    initial begin
        repeat (6000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end
endmodule : smc_standby_bench
